// ==== inc/cich_pkg.sv ====
// Codes, timing counts and types of the C/I channel handler.
// What this block does
// - Decode the whole basic and extended C/I code sets; encode all of them but the lost-level code.
// - Basic mode also takes test mode two and software clear codes.
// - Never send lost-level code; with no valid signal report resync.
// - A command defined in one mode is accepted at that code in both.
// - The error indication is sent in extended mode too.
// - Serial output is open-drain; shared slots wire-AND bit by bit.
// - Deactivate request sends INFO0, then deactivation indication.
// - Code 0001 performs a soft reset in both modes.
// - Code 0010 enters test mode one, sending single zeros.
// - Code 0011 enters test mode two, sending continuous zeros.
// - Resync command 0100 sends INFO2 in both modes.
// - Activation request 1000 sends INFO2; receiver reports bus reaction.
// - Code 1010 sends INFO2 with test loop two closed.
// - Activation indication 1100 sends INFO4; controller waits for ours.
// - Code 1110 sends INFO4 with test loop two closed.
// - Deactivate confirm 1111 powers down and sends INFO0.
// - In a loop, ignore bus INFO3 and sync on our own looped signal.
// - Send clock request 0000 when clocks are needed in reset or in power-down.
// - Send error 0110 while reset pin and zero-test pin are both low.
// - Send activation request 1000 when any line signal is received.
// - Send activation indication 1100 once the receiver is synchronized.
// - Send 1111 after 32 ms, or after 16 ms of INFO0 after deactivation.
package cich_pkg;
    localparam logic [3:0] CMD_DEACTIVATE_REQUEST  = 4'h0;
    localparam logic [3:0] CMD_SOFTWARE_CLEAR      = 4'h1;
    localparam logic [3:0] CMD_TEST_MODE_ONE       = 4'h2;
    localparam logic [3:0] CMD_TEST_MODE_TWO       = 4'h3;
    localparam logic [3:0] CMD_RESYNC_DOWN         = 4'h4;
    localparam logic [3:0] CMD_ACTIVATION_REQ_DOWN = 4'h8;
    localparam logic [3:0] CMD_ACTIVATE_LOOP_REQ   = 4'ha;
    localparam logic [3:0] CMD_ACTIVATION_IND_DOWN = 4'hc;
    localparam logic [3:0] CMD_ACTIVATE_LOOP_IND   = 4'he;
    localparam logic [3:0] CMD_DEACTIVATE_CONFIRM  = 4'hf;
    localparam logic [3:0] CMD_RESET_VALUE         = 4'h5;

    localparam logic [3:0] IND_CLOCK_REQUEST   = 4'h0;
    localparam logic [3:0] IND_RESYNC_UP       = 4'h4;
    localparam logic [3:0] IND_ERROR           = 4'h6;
    localparam logic [3:0] IND_ACTIVATION_REQ  = 4'h8;
    localparam logic [3:0] IND_ACTIVATION_UP   = 4'hc;
    localparam logic [3:0] IND_DEACTIVATION_UP = 4'hf;

    localparam logic [7:0] CI_FIRST_BIT = 8'h1a;
    localparam logic [7:0] CI_LAST_BIT  = 8'h1d;
    localparam logic [7:0] BIT_CNT_MAX  = 8'hff;

    localparam int unsigned PIN_COUNT = 5;
    localparam logic [4:0]  PIN_RESET_VALUE = 5'h1c;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned MS_IN_PS      = 1000000000;
    localparam int unsigned CYC_PER_MS    = MS_IN_PS / CLK_PERIOD_PS;
    localparam logic [5:0]  DEACT_TIMEOUT_MS = 6'h20;
    localparam logic [5:0]  INFO0_QUIET_MS   = 6'h10;

    typedef enum logic [2:0] {
        TX_INFO0,
        TX_INFO2,
        TX_INFO4,
        TX_SINGLE_ZEROS,
        TX_CONT_ZEROS
    } cich_tx_t;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_PEND_ACT,
        ST_ACTIVE,
        ST_LOST_SYNC,
        ST_PEND_DEACT,
        ST_TEST
    } cich_state_t;
endpackage

// ==== src/cich_sync3.sv ====
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module cich_sync3 #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys,  // System clock.
    input  wire logic         reset_n,  // Asynchronous reset.
    input  wire logic [W-1:0] pin_in,   // Raw pin levels.
    output logic      [W-1:0] pin_out   // Filtered levels.
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    pin_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule

// ==== src/cich_ms_tick.sv ====
// Millisecond enable pulse divided from the system clock.
`timescale 1ns/1ps
module cich_ms_tick #(
    parameter int unsigned CYC = 200000
) (
    input  wire logic clk_sys,  // System clock.
    input  wire logic reset_n,  // Asynchronous reset.
    output logic      tick      // One-cycle pulse each millisecond.
);
    logic [31:0] count;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count >= CYC - 1) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule

// ==== src/cich_handler.sv ====
// C/I channel command decoder and indication encoder, NT side.
`timescale 1ns/1ps
module cich_handler #(
    parameter int unsigned CYC_PER_MS = cich_pkg::CYC_PER_MS
) (
    input  wire logic        clk_sys,          // System clock.
    input  wire logic        reset_n,          // Asynchronous reset.
    input  wire logic        gci_fsc,          // Frame sync pin.
    input  wire logic        gci_dcl,          // Data clock pin.
    input  wire logic        gci_din,          // Serial data in pin.
    output logic             gci_dout_o,       // Serial out level.
    output logic             gci_dout_oe,      // Pull-down enable.
    input  wire logic        hw_reset_pin_n,   // Hardware reset pin.
    input  wire logic        cz_test_pin_n,    // Zero test pin.
    input  wire logic        mode_ext,         // Extended code set.
    input  wire logic        rx_ami_detect,    // Line signal seen.
    input  wire logic        rx_info3_sync,    // Synced on INFO3.
    input  wire logic        rx_loop_sync,     // Synced on loop.
    input  wire logic        rx_info0,         // INFO0 received.
    input  wire logic        clk_needed,       // Clocks required.
    output cich_pkg::cich_tx_t tx_info,        // Line signal to send.
    output logic             loop2_close,      // Test loop closed.
    output logic             soft_clear_pulse, // Soft reset pulse.
    output logic             power_down,       // Power-down state.
    output logic       [3:0] ind_code,         // Current indication.
    output logic       [3:0] cmd_code          // Last command.
);
    import cich_pkg::*;

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------

    // True for bit slots that carry the C/I code.
    function automatic logic ci_slot(input logic [7:0] cnt);
        ci_slot = (cnt >= CI_FIRST_BIT) && (cnt <= CI_LAST_BIT);
    endfunction

    // Codes that have a meaning as a command in either mode.
    function automatic logic cmd_known(input logic [3:0] c);
        case (c)
            CMD_DEACTIVATE_REQUEST,
            CMD_SOFTWARE_CLEAR,
            CMD_TEST_MODE_ONE,
            CMD_TEST_MODE_TWO,
            CMD_RESYNC_DOWN,
            CMD_ACTIVATION_REQ_DOWN,
            CMD_ACTIVATE_LOOP_REQ,
            CMD_ACTIVATION_IND_DOWN,
            CMD_ACTIVATE_LOOP_IND,
            CMD_DEACTIVATE_CONFIRM: cmd_known = 1'b1;
            default:                cmd_known = 1'b0;
        endcase
    endfunction

    // --------------------------------------------------------
    // Pin synchronisation and timing
    // --------------------------------------------------------

    logic [PIN_COUNT-1:0] pin_sync;
    logic                 din_s;
    logic                 hw_n_s;
    logic                 czt_n_s;
    logic                 fsc_s;
    logic                 dcl_s;
    logic                 ms_tick;

    assign {din_s, hw_n_s, czt_n_s, fsc_s, dcl_s} = pin_sync;

    cich_sync3 #(
        .W       (PIN_COUNT),
        .RST_VAL (PIN_RESET_VALUE)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin_in  ({gci_din, hw_reset_pin_n, cz_test_pin_n,
                   gci_fsc, gci_dcl}),
        .pin_out (pin_sync)
    );

    cich_ms_tick #(
        .CYC     (CYC_PER_MS)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (ms_tick)
    );

    // --------------------------------------------------------
    // Frame and bit counting
    // --------------------------------------------------------

    logic       fsc_d;
    logic       dcl_d;
    logic       fsc_rise;
    logic       dcl_rise;
    logic       dcl_fall;
    logic [7:0] bit_cnt;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fsc_d <= 1'b0;
            dcl_d <= 1'b0;
        end else begin
            fsc_d <= fsc_s;
            dcl_d <= dcl_s;
        end
    end

    assign fsc_rise = fsc_s & ~fsc_d;
    assign dcl_rise = dcl_s & ~dcl_d;
    assign dcl_fall = ~dcl_s & dcl_d;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= BIT_CNT_MAX;
        end else if (fsc_rise) begin
            bit_cnt <= 8'h00;
        end else if (dcl_fall && bit_cnt != BIT_CNT_MAX) begin
            bit_cnt <= bit_cnt + 8'h01;
        end
    end

    // --------------------------------------------------------
    // Command reception
    // --------------------------------------------------------

    logic [3:0] rx_shift;
    logic       rx_done;
    logic       cmd_new;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_shift <= 4'h0;
        end else if (dcl_rise && ci_slot(bit_cnt)) begin
            rx_shift <= {rx_shift[2:0], din_s};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_done <= 1'b0;
        end else begin
            rx_done <= dcl_rise && (bit_cnt == CI_LAST_BIT);
        end
    end

    // A code repeated in later frames is not acted on again.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cmd_code <= CMD_RESET_VALUE;
            cmd_new  <= 1'b0;
        end else if (rx_done && rx_shift != cmd_code) begin
            cmd_code <= rx_shift;
            cmd_new  <= 1'b1;
        end else begin
            cmd_new  <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // Receiver status
    // --------------------------------------------------------

    logic        synced;
    logic        ami_seen;
    logic        err_pins;
    logic        deact_done;
    cich_state_t state;

    // Inside a loop the bus signal is ignored and our own is tracked.
    assign synced   = loop2_close ? rx_loop_sync : rx_info3_sync;
    assign ami_seen = rx_ami_detect & ~loop2_close;
    assign err_pins = ~hw_n_s & ~czt_n_s;

    // --------------------------------------------------------
    // Deactivation timers
    // --------------------------------------------------------

    logic [5:0] t_all_ms;
    logic [5:0] t_quiet_ms;

    assign deact_done = (t_all_ms >= DEACT_TIMEOUT_MS) ||
                        (t_quiet_ms >= INFO0_QUIET_MS);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            t_all_ms   <= 6'h00;
            t_quiet_ms <= 6'h00;
        end else if (state != ST_PEND_DEACT) begin
            t_all_ms   <= 6'h00;
            t_quiet_ms <= 6'h00;
        end else if (ms_tick && !deact_done) begin
            t_all_ms   <= t_all_ms + 6'h01;
            t_quiet_ms <= rx_info0 ? t_quiet_ms + 6'h01 : 6'h00;
        end
    end

    // --------------------------------------------------------
    // Activation state
    // --------------------------------------------------------

    // Both modes decode the same merged code set, so mode_ext
    // does not gate any command.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_RESET;
        end else if (!hw_n_s) begin
            state <= ST_RESET;
        end else if (cmd_new) begin
            case (cmd_code)
                CMD_DEACTIVATE_REQUEST: begin
                    state <= ST_PEND_DEACT;
                end
                CMD_SOFTWARE_CLEAR: begin
                    state <= ST_RESET;
                end
                CMD_TEST_MODE_ONE,
                CMD_TEST_MODE_TWO: begin
                    state <= ST_TEST;
                end
                CMD_RESYNC_DOWN,
                CMD_ACTIVATION_REQ_DOWN,
                CMD_ACTIVATE_LOOP_REQ,
                CMD_ACTIVATION_IND_DOWN,
                CMD_ACTIVATE_LOOP_IND: begin
                    state <= ST_PEND_ACT;
                end
                CMD_DEACTIVATE_CONFIRM: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= state;
                end
            endcase
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ami_seen) begin
                        state <= ST_PEND_ACT;
                    end
                end
                ST_PEND_ACT: begin
                    if (synced) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!synced) begin
                        state <= ST_LOST_SYNC;
                    end
                end
                ST_LOST_SYNC: begin
                    if (synced) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_PEND_DEACT: begin
                    if (deact_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // Line transmit selection
    // --------------------------------------------------------

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_info <= TX_INFO0;
        end else if (!hw_n_s) begin
            tx_info <= TX_INFO0;
        end else if (!czt_n_s) begin
            tx_info <= TX_CONT_ZEROS;
        end else if (cmd_new) begin
            case (cmd_code)
                CMD_DEACTIVATE_REQUEST,
                CMD_SOFTWARE_CLEAR: begin
                    tx_info <= TX_INFO0;
                end
                CMD_TEST_MODE_ONE: begin
                    tx_info <= TX_SINGLE_ZEROS;
                end
                CMD_TEST_MODE_TWO: begin
                    tx_info <= TX_CONT_ZEROS;
                end
                CMD_RESYNC_DOWN: begin
                    tx_info <= TX_INFO2;
                end
                CMD_ACTIVATION_REQ_DOWN,
                CMD_ACTIVATE_LOOP_REQ: begin
                    tx_info <= TX_INFO2;
                end
                CMD_ACTIVATION_IND_DOWN,
                CMD_ACTIVATE_LOOP_IND: begin
                    tx_info <= TX_INFO4;
                end
                CMD_DEACTIVATE_CONFIRM: begin
                    tx_info <= TX_INFO0;
                end
                default: begin
                    tx_info <= tx_info;
                end
            endcase
        end else if (state == ST_IDLE && ami_seen) begin
            tx_info <= TX_INFO2;
        end else if (state == ST_ACTIVE && !synced) begin
            tx_info <= TX_INFO2;
        end
    end

    // --------------------------------------------------------
    // Loop, soft reset and power-down controls
    // --------------------------------------------------------

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loop2_close <= 1'b0;
        end else if (!hw_n_s) begin
            loop2_close <= 1'b0;
        end else if (cmd_new && cmd_known(cmd_code)) begin
            loop2_close <= (cmd_code == CMD_ACTIVATE_LOOP_REQ) ||
                           (cmd_code == CMD_ACTIVATE_LOOP_IND);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            soft_clear_pulse <= 1'b0;
        end else begin
            soft_clear_pulse <= cmd_new &&
                                (cmd_code == CMD_SOFTWARE_CLEAR);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            power_down <= 1'b0;
        end else if (!hw_n_s) begin
            power_down <= 1'b0;
        end else if (cmd_new && cmd_known(cmd_code)) begin
            power_down <= (cmd_code == CMD_DEACTIVATE_CONFIRM);
        end else if (state == ST_IDLE && ami_seen) begin
            power_down <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // Indication encoding
    // --------------------------------------------------------

    // The lost-level code is never produced; resync stands in for it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ind_code <= IND_DEACTIVATION_UP;
        end else if (err_pins) begin
            ind_code <= IND_ERROR;
        end else begin
            case (state)
                ST_RESET: begin
                    ind_code <= clk_needed ? IND_CLOCK_REQUEST
                                           : IND_DEACTIVATION_UP;
                end
                ST_IDLE: begin
                    ind_code <= (power_down && clk_needed)
                                ? IND_CLOCK_REQUEST
                                : IND_DEACTIVATION_UP;
                end
                ST_PEND_ACT: begin
                    if (synced) begin
                        ind_code <= IND_ACTIVATION_UP;
                    end else if (ami_seen) begin
                        ind_code <= IND_ACTIVATION_REQ;
                    end else begin
                        ind_code <= IND_RESYNC_UP;
                    end
                end
                ST_ACTIVE: begin
                    ind_code <= IND_ACTIVATION_UP;
                end
                ST_LOST_SYNC: begin
                    ind_code <= IND_RESYNC_UP;
                end
                ST_PEND_DEACT: begin
                    ind_code <= mode_ext ? IND_CLOCK_REQUEST
                                         : IND_RESYNC_UP;
                end
                ST_TEST: begin
                    ind_code <= IND_CLOCK_REQUEST;
                end
                default: begin
                    ind_code <= IND_DEACTIVATION_UP;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // Indication transmission
    // --------------------------------------------------------

    logic [3:0] ind_frame;
    logic [1:0] tx_idx;

    // The code is frozen for a whole frame and resent each frame.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ind_frame <= IND_DEACTIVATION_UP;
        end else if (fsc_rise) begin
            ind_frame <= ind_code;
        end
    end

    assign tx_idx = 2'(CI_LAST_BIT - bit_cnt);

    // Only zeros are driven; a one releases the shared line, so several
    // devices on one slot combine as a wired-AND.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gci_dout_o  <= 1'b0;
            gci_dout_oe <= 1'b0;
        end else begin
            gci_dout_o  <= 1'b0;
            gci_dout_oe <= ci_slot(bit_cnt) &&
                           !ind_frame[tx_idx];
        end
    end
endmodule

// ==== tb/cich_props.sv ====
// Port checks for the C/I channel handler.
`timescale 1ns/1ps
module cich_props import cich_pkg::*; (
    input wire logic          clk_sys,          // Clock.
    input wire logic          reset_n,          // Reset.
    input wire logic          hw_reset_pin_n,   // Reset pin.
    input wire logic          cz_test_pin_n,    // Zero test pin.
    input cich_pkg::cich_tx_t tx_info,          // Line signal.
    input wire logic          loop2_close,      // Loop closed.
    input wire logic          soft_clear_pulse, // Soft reset.
    input wire logic          power_down,       // Power down.
    input wire logic [3:0]    ind_code,         // Indication.
    input wire logic [3:0]    cmd_code          // Command.
);
    logic [3:0] pc;
    wire        nc = cmd_code != pc;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pc <= 4'h5;
        end else begin
            pc <= cmd_code;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    no_lost_level_a: assert property (ind_code != 4'h1)
        else $error("lost level code sent");
    error_ind_a: assert property (
        (!hw_reset_pin_n && !cz_test_pin_n) [*8] |-> ##[0:4] ind_code == 4'h6
    ) else $error("error indication missing");
    test_mode_a: assert property (
        nc && cmd_code[3:1] == 3'h1 |=>
        tx_info == ($past(cmd_code[0]) ? TX_CONT_ZEROS : TX_SINGLE_ZEROS)
    ) else $error("test mode signal wrong");
    info_two_a: assert property (
        nc && cmd_code[3] && !cmd_code[2] && !cmd_code[0] |=>
        tx_info == TX_INFO2 && loop2_close == $past(cmd_code[1])
    ) else $error("activation request signal wrong");
    info_four_a: assert property (
        nc && cmd_code[3:2] == 2'h3 && !cmd_code[0] |=>
        tx_info == TX_INFO4 && loop2_close == $past(cmd_code[1])
    ) else $error("activation indication signal wrong");
    deact_req_a: assert property (
        nc && cmd_code == 4'h0 |=> tx_info == TX_INFO0
    ) else $error("deactivation signal wrong");
    deact_confirm_a: assert property (
        nc && cmd_code == 4'hf |=> power_down && tx_info == TX_INFO0
    ) else $error("power down missing");
    soft_clear_a: assert property (
        nc && cmd_code == 4'h1 |=> soft_clear_pulse ##1 !soft_clear_pulse
    ) else $error("soft clear pulse wrong");
endmodule
bind cich_handler cich_props i_cich_props (.clk_sys, .reset_n, .hw_reset_pin_n, .cz_test_pin_n,
    .tx_info, .loop2_close, .soft_clear_pulse, .power_down, .ind_code, .cmd_code);

// ==== tb/cich_ctl_model.sv ====
// Layer-2 controller model driving the frame bus and reading indications.
`timescale 1ns/1ps
module cich_ctl_model (
    input wire logic  clk_sys, // System clock.
    input wire logic  line_up, // Upstream line level.
    output logic      fsc,     // Frame sync.
    output logic      dcl,     // Bit clock.
    output logic      din,     // Downstream data.
    output logic[3:0] ind      // Slot indication seen.
);
    initial begin
        fsc = 1'b0;
        dcl = 1'b1;
        din = 1'b1;
        ind = 4'hf;
    end
    // One frame of 32 bits, code in bits 26 to 29, idle line pulled high.
    task automatic frame(input logic [3:0] code);
        repeat (4) @(negedge clk_sys);
        fsc = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int b = 1; b < 32; b++) begin
            dcl = 1'b0;
            fsc = 1'b0;
            din = (b >= 26 && b <= 29) ? code[29-b] : 1'b1;
            repeat (4) @(negedge clk_sys);
            dcl = 1'b1;
            repeat (2) @(negedge clk_sys);
            if (b >= 26 && b <= 29) begin
                ind[29-b] = line_up;
            end
            repeat (2) @(negedge clk_sys);
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Testbench for the C/I channel handler.
`timescale 1ns/1ps
module tb_top;
    import cich_pkg::*;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic       hw_n = 1'b1, cz_n = 1'b1, ext = 1'b0, ami = 1'b0, s3 = 1'b0, sl = 1'b0;
    logic       r0 = 1'b0, ckn = 1'b0;
    logic       fsc, dcl, din, oe, lp, pd, dout;
    logic [3:0] ind, cmd;
    cich_tx_t   tx;
    int         errors = 0;
    int         num_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    cich_ctl_model i_cich_ctl_model (.clk_sys, .line_up(~oe), .fsc, .dcl, .din, .ind());
    cich_handler #(.CYC_PER_MS(20)) i_cich_handler (.clk_sys, .reset_n, .gci_fsc(fsc),
        .gci_dcl(dcl), .gci_din(din), .gci_dout_o(dout), .gci_dout_oe(oe), .hw_reset_pin_n(hw_n),
        .cz_test_pin_n(cz_n), .mode_ext(ext), .rx_ami_detect(ami), .rx_info3_sync(s3),
        .rx_loop_sync(sl), .rx_info0(r0), .clk_needed(ckn), .tx_info(tx), .loop2_close(lp),
        .soft_clear_pulse(), .power_down(pd), .ind_code(ind), .cmd_code(cmd));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic f(input logic [3:0] c);
        i_cich_ctl_model.frame(c);
    endtask
    task automatic t_act;
        f(4'h8);
        chk({1'b0, tx}, {1'b0, TX_INFO2});
        chk(ind, 4'h4);
        ami = 1'b1;
        w(3);
        chk(ind, 4'h8);
        f(4'h8);
        chk(i_cich_ctl_model.ind, 4'h8);
        chk({3'h0, dout}, 4'h0);
        s3 = 1'b1;
        w(3);
        chk(ind, 4'hc);
        f(4'hc); // Sent only once the activation indication is up.
        chk({1'b0, tx}, {1'b0, TX_INFO4});
        s3 = 1'b0;
        ami = 1'b0;
        w(3);
        chk(ind, 4'h4);
    endtask
    task automatic t_loop;
        f(4'ha);
        chk({lp, tx}, {1'b1, TX_INFO2});
        s3 = 1'b1;
        w(3);
        chk(ind, 4'h4);
        sl = 1'b1;
        w(3);
        chk(ind, 4'hc);
        f(4'he);
        chk({lp, tx}, {1'b1, TX_INFO4});
        s3 = 1'b0;
        sl = 1'b0;
    endtask
    task automatic t_test;
        for (int m = 0; m < 2; m++) begin
            ext = m[0];
            f(4'h2);
            chk({1'b0, tx}, {1'b0, TX_SINGLE_ZEROS});
            f(4'h3);
            chk({1'b0, tx}, {1'b0, TX_CONT_ZEROS});
            f(4'h4);
            chk({1'b0, tx}, {1'b0, TX_INFO2});
            f(4'h6);
            chk({1'b0, tx}, {1'b0, TX_INFO2});
            f(4'h1);
            chk(cmd, 4'h1);
            chk(ind, 4'hf);
        end
    endtask
    task automatic t_deact;
        f(4'h0);
        chk({1'b0, tx}, {1'b0, TX_INFO0});
        r0 = 1'b1;
        w(400);
        chk(ind, 4'hf);
        f(4'hf);
        chk({pd, tx}, {1'b1, TX_INFO0});
        ckn = 1'b1;
        w(3);
        chk(ind, 4'h0);
        r0 = 1'b0;
        f(4'h0);
        w(500);
        chk(ind, 4'h0);
        w(200);
        chk(ind, 4'hf);
    endtask
    task automatic t_err;
        hw_n = 1'b0;
        cz_n = 1'b0;
        w(8);
        chk(ind, 4'h6);
        ext = 1'b0;
        w(3);
        chk(ind, 4'h6);
    endtask
    initial begin
        w(4);
        reset_n = 1'b1;
        w(2);
        t_act;
        t_loop;
        t_test;
        t_deact;
        t_err;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        print_verdict;
    end
endmodule
